// *** rtl/gpint_port.sv ***
// general-purpose port with per-pin interrupts behind an axi4-lite slave
`timescale 1ns/1ps
module gpint_port #(
    parameter int N = 32
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [gpint_pkg::GPINT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic      [1:0]                   s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [gpint_pkg::GPINT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic      [31:0]                  s_axi_rdata,
    output logic      [1:0]                   s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic [N-1:0]                 pin_in,
    output logic      [N-1:0]                 pin_out,
    output logic      [N-1:0]                 pin_oe_n,
    output logic                              irq
);
    logic [N-1:0]   out_latch;
    logic [N-1:0]   pin_dir_select;
    logic [N-1:0]   int_stat;
    logic [N-1:0]   int_en;
    logic [2*N-1:0] det_type;
    logic [N-1:0]   pin_level;
    logic [N-1:0]   pin_event;

    gpint_detect #(.N(N)) u_detect (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_raw   (pin_in),
        .det_type  (det_type),
        .pin_level (pin_level),
        .pin_event (pin_event)
    );

    // ---------------- write channel ----------------
    logic [gpint_pkg::GPINT_ADDR_W-1:0] aw_addr;
    logic                               aw_held;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;
    logic                               w_held;
    logic                               wr_go;

    // take address and data in either order, then act once both are held
    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_go) begin
                aw_held       <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_go) begin
                w_held       <= 1'b0;
            end
        end
    end

    logic wr_known;
    always_comb begin
        case (aw_addr)
            gpint_pkg::GPINT_OFF_OUT, gpint_pkg::GPINT_OFF_SET, gpint_pkg::GPINT_OFF_CLR,
            gpint_pkg::GPINT_OFF_TGL, gpint_pkg::GPINT_OFF_PINWR, gpint_pkg::GPINT_OFF_CFG,
            gpint_pkg::GPINT_OFF_DIR, gpint_pkg::GPINT_OFF_STAT, gpint_pkg::GPINT_OFF_IENSET,
            gpint_pkg::GPINT_OFF_IENCLR, gpint_pkg::GPINT_OFF_IEN, gpint_pkg::GPINT_OFF_TYPSEL,
            gpint_pkg::GPINT_OFF_TYPE:   wr_known = 1'b1;
            default:                     wr_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gpint_pkg::GPINT_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? gpint_pkg::GPINT_RESP_OKAY : gpint_pkg::GPINT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // byte-lane mask so partial writes leave other lanes alone
    logic [31:0] lane_mask;
    logic [N-1:0] wmask;
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign lane_mask[8*b +: 8] = {8{w_strb[b]}};
        end
    endgenerate
    assign wmask = N'(w_data & lane_mask);

    localparam int GPINT_PIN_SEL = gpint_pkg::GPINT_PIN_W;
    logic                     wr_ok;
    logic [GPINT_PIN_SEL-1:0] pin_idx;
    logic                     pin_idx_ok;
    assign wr_ok      = wr_go && wr_known;
    assign pin_idx    = w_data[gpint_pkg::GPINT_PIN_LSB +: GPINT_PIN_SEL];
    // a pin index past the port width is dropped rather than wrapped onto a real pin
    assign pin_idx_ok = 32'(pin_idx) < N;

    // one strobe per writable register from CFG to TYPE, so each concern that uses them tests a single term
    logic wr_cfg;
    logic wr_dir;
    logic wr_stat;
    logic wr_ienset;
    logic wr_ienclr;
    logic wr_ien;
    logic wr_typsel;
    logic wr_type;
    assign wr_cfg    = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_CFG);
    assign wr_dir    = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_DIR);
    assign wr_stat   = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_STAT);
    assign wr_ienset = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_IENSET);
    assign wr_ienclr = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_IENCLR);
    assign wr_ien    = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_IEN);
    assign wr_typsel = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_TYPSEL);
    assign wr_type   = wr_ok && (aw_addr == gpint_pkg::GPINT_OFF_TYPE);

    // ---------------- output latch and direction ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_latch <= '0;
        end else if (wr_ok) begin
            case (aw_addr)
                gpint_pkg::GPINT_OFF_OUT: out_latch <= (out_latch & ~N'(lane_mask)) | wmask;
                gpint_pkg::GPINT_OFF_SET: out_latch <= out_latch | wmask;    // R2
                gpint_pkg::GPINT_OFF_CLR: out_latch <= out_latch & ~wmask;   // R3
                gpint_pkg::GPINT_OFF_TGL: out_latch <= out_latch ^ wmask;    // R4
                gpint_pkg::GPINT_OFF_PINWR: begin
                    if (pin_idx_ok) begin
                        out_latch[pin_idx] <= w_data[gpint_pkg::GPINT_LVL_BIT];   // R1
                    end
                end
                gpint_pkg::GPINT_OFF_CFG: begin
                    if (pin_idx_ok) begin
                        out_latch[pin_idx] <= w_data[gpint_pkg::GPINT_CFGLVL_BIT]; // R8
                    end
                end
                default: out_latch <= out_latch;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_dir_select <= {N{gpint_pkg::DIR_CODE_IN}};
        end else if (wr_dir) begin
            pin_dir_select <= (pin_dir_select & ~N'(lane_mask)) | wmask;   // R6
        end else if (wr_cfg && pin_idx_ok) begin
            pin_dir_select[pin_idx] <= w_data[gpint_pkg::GPINT_LVL_BIT];  // R6
        end
    end

    // an input pin keeps its latch value but never drives the pad
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end else begin
            pin_out  <= out_latch & pin_dir_select;                          // R7
            pin_oe_n <= ~pin_dir_select;                                     // R7
        end
    end

    // ---------------- interrupt configuration ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_en <= '0;
        end else if (wr_ienset) begin
            int_en <= int_en | wmask;                                        // R14
        end else if (wr_ienclr) begin
            int_en <= int_en & ~wmask;                                       // R14
        end else if (wr_ien) begin
            int_en <= (int_en & ~N'(lane_mask)) | wmask;
        end
    end

    // type select: held code, then a mask write applies it to chosen pins
    logic [1:0] type_code;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            type_code <= gpint_pkg::GPINT_DET_HIGH;
        end else if (wr_typsel) begin
            type_code <= w_data[gpint_pkg::GPINT_TYP_LSB +: 2];
        end
    end

    genvar p;
    generate
        for (p = 0; p < N; p++) begin : g_type
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    det_type[2*p +: 2] <= gpint_pkg::GPINT_DET_HIGH;
                end else if (wr_type && wmask[p]) begin
                    det_type[2*p +: 2] <= type_code;                         // R12 R13
                end
            end
        end
    endgenerate

    // ---------------- read channel ----------------
    logic rd_was_stat;
    logic rd_stat;
    assign rd_stat = s_axi_rvalid && s_axi_rready && rd_was_stat;

    // clears gathered into one mask; a completed read of the status word clears every flag
    logic [N-1:0] stat_clr;
    always_comb begin
        stat_clr = '0;
        if (wr_stat) begin
            stat_clr = wmask;                                                // R10
        end
        if (rd_stat) begin
            stat_clr = '1;
        end
    end

    // event set wins over any clear in the same cycle; level sources re-set at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat <= '0;
        end else begin
            int_stat <= (int_stat & ~stat_clr) | pin_event;                  // R11
        end
    end

    // read word picked from the request address; unmapped offsets answer with an error
    logic [31:0] rd_word;
    logic        rd_known;
    always_comb begin
        rd_word  = '0;
        rd_known = 1'b1;
        case (s_axi_araddr)
            gpint_pkg::GPINT_OFF_OUT:    rd_word = 32'(out_latch);
            gpint_pkg::GPINT_OFF_DIR:    rd_word = 32'(pin_dir_select);
            gpint_pkg::GPINT_OFF_IN:     rd_word = 32'(pin_level);           // R5
            gpint_pkg::GPINT_OFF_STAT:   rd_word = 32'(int_stat);            // R9
            gpint_pkg::GPINT_OFF_IEN:    rd_word = 32'(int_en);
            gpint_pkg::GPINT_OFF_TYPSEL: rd_word = 32'(type_code);
            default:                     rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_en);                                     // R15
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= gpint_pkg::GPINT_RESP_OKAY;
            rd_was_stat   <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;                                     // R5 R9
                s_axi_rresp  <= rd_known ? gpint_pkg::GPINT_RESP_OKAY
                                         : gpint_pkg::GPINT_RESP_SLVERR;
                rd_was_stat  <= (s_axi_araddr == gpint_pkg::GPINT_OFF_STAT);
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rd_was_stat  <= 1'b0;
            end
        end
    end
endmodule

// *** rtl/gpint_pkg.sv ***
// constants and types for the general-purpose port with pin interrupts
// Overview of operation
// R1 - A single-pin write drives the chosen pin's output latch to the written 1 or 0, other pins unchanged.
// R2 - Set-by-mask forces every masked output latch bit to 1, others untouched.
// R3 - Clear-by-mask forces every masked output latch bit to 0, others untouched.
// R4 - Toggle-by-mask inverts every masked output latch bit, others unchanged.
// R5 - Reading the port input returns the sampled level of every pin in one word, one bit per pin.
// R6 - Direction code 0 makes a pin an input and code 1 makes it an output.
// R7 - A pin is either input or output, and an input pin's output level has no effect on the pin.
// R8 - Configuring a pin takes an initial output level into its latch, unused while it is an input.
// R9 - Reading the interrupt status returns every pin's pending flag in one word, one bit per pin.
// R10 - Writing a mask clears the status flag of each selected pin and leaves the others pending.
// R11 - A flag stays set until cleared, and a level still present sets it again at once.
// R12 - Each pin can detect a high level or a low level.
// R13 - Each pin can detect a rising edge or a falling edge.
// R14 - Per-pin interrupt enable is set and cleared by mask, touching only masked pins.
// R15 - The port interrupt is high while any pin has both its flag and its enable set.
package gpint_pkg;

    localparam int          GPINT_ADDR_W     = 6;
    localparam logic [5:0]  GPINT_OFF_OUT    = 6'h00;
    localparam logic [5:0]  GPINT_OFF_SET    = 6'h04;
    localparam logic [5:0]  GPINT_OFF_CLR    = 6'h08;
    localparam logic [5:0]  GPINT_OFF_TGL    = 6'h0c;
    localparam logic [5:0]  GPINT_OFF_PINWR  = 6'h10;
    localparam logic [5:0]  GPINT_OFF_CFG    = 6'h14;
    localparam logic [5:0]  GPINT_OFF_DIR    = 6'h18;
    localparam logic [5:0]  GPINT_OFF_IN     = 6'h1c;
    localparam logic [5:0]  GPINT_OFF_STAT   = 6'h20;
    localparam logic [5:0]  GPINT_OFF_IENSET = 6'h24;
    localparam logic [5:0]  GPINT_OFF_IENCLR = 6'h28;
    localparam logic [5:0]  GPINT_OFF_IEN    = 6'h2c;
    localparam logic [5:0]  GPINT_OFF_TYPSEL = 6'h30;
    localparam logic [5:0]  GPINT_OFF_TYPE   = 6'h34;

    // pin write / config word: bit 0 level or direction, bit 8 level, bits 20:16 pin index
    localparam int          GPINT_LVL_BIT    = 0;
    localparam int          GPINT_CFGLVL_BIT = 8;
    localparam int          GPINT_PIN_LSB    = 16;
    localparam int          GPINT_PIN_W      = 5;
    // type select word: bits 1:0 type code, written to pins given by the mask in the data word of a later TYPE write
    localparam int          GPINT_TYP_LSB    = 0;

    localparam logic        DIR_CODE_IN      = 1'b0;
    localparam logic        DIR_CODE_OUT     = 1'b1;

    typedef enum logic [1:0] {
        GPINT_DET_HIGH = 2'h0,
        GPINT_DET_RISE = 2'h1,
        GPINT_DET_LOW  = 2'h2,
        GPINT_DET_FALL = 2'h3
    } gpint_det_t;

    localparam logic [1:0]  GPINT_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  GPINT_RESP_SLVERR = 2'h2;

endpackage

// *** rtl/gpint_detect.sv ***
// per-pin input synchroniser and event detector
`timescale 1ns/1ps
module gpint_detect #(
    parameter int N = 32
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [N-1:0] pin_raw,
    input  wire logic [2*N-1:0] det_type,
    output logic      [N-1:0] pin_level,
    output logic      [N-1:0] pin_event
);
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync3;

    // three stages; second and third must agree before a change is accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1     <= '0;
            sync2     <= '0;
            sync3     <= '0;
            pin_level <= '0;
        end else begin
            sync1     <= pin_raw;
            sync2     <= sync1;
            sync3     <= sync2;
            pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
        end
    end

    logic [N-1:0] prev_level;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_level <= '0;
        end else begin
            prev_level <= pin_level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_det
            always_comb begin
                case (gpint_pkg::gpint_det_t'(det_type[2*i +: 2]))
                    gpint_pkg::GPINT_DET_HIGH: pin_event[i] = pin_level[i];    // R12
                    gpint_pkg::GPINT_DET_LOW:  pin_event[i] = !pin_level[i];   // R12
                    gpint_pkg::GPINT_DET_RISE: pin_event[i] = pin_level[i] & !prev_level[i]; // R13
                    gpint_pkg::GPINT_DET_FALL: pin_event[i] = !pin_level[i] & prev_level[i]; // R13
                    default:                   pin_event[i] = 1'b0;
                endcase
            end
        end
    endgenerate
endmodule

// *** test/gpint_port_props.sv ***
// assertion checker for the port's bus handshakes and pin drive
`timescale 1ns/1ps
module gpint_port_props #(
    parameter int N = 32
) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    input wire logic [N-1:0]  pin_out,
    input wire logic [N-1:0]  pin_oe_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence write_recent_s;
        s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endsequence

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    read_answer_a: assert property (read_taken_s |=> s_axi_rvalid)
        else $error("read answer late");
    read_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answer without request");
    write_answer_a: assert property (write_taken_s |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    refused_data_a: assert property (s_axi_rvalid && s_axi_rresp == gpint_pkg::GPINT_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
    input_quiet_a: assert property ((pin_out & pin_oe_n) == '0)
        else $error("input pin driven high");
    drive_timing_a: assert property (!$stable(pin_out) || !$stable(pin_oe_n) |-> write_recent_s)
        else $error("pin drive changed without a write");
endmodule

bind gpint_port gpint_port_props #(.N(N)) u_gpint_port_props (.*);

// *** test/gpint_board.sv ***
// board side of the port pins
`timescale 1ns/1ps
module gpint_board #(
    parameter int N = 32
) (
    input  wire logic [N-1:0] pin_out,
    input  wire logic [N-1:0] pin_oe_n,
    input  wire logic [N-1:0] ext_level,
    output logic      [N-1:0] pin_in
);
    // a driven pad reads back its own level, an undriven one shows the board's level
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// *** test/gpint_port_test.sv ***
// self-checking bench for the port: bus tasks and register sequences
`timescale 1ns/1ps
module gpint_port_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, irq;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata, s_axi_rdata, pin_in, pin_out, pin_oe_n, ext, exp_out, dir;
    int          fail_count, samples_checked, cycles;
    localparam logic [1:0] ERR = gpint_pkg::GPINT_RESP_SLVERR;

    gpint_port u_gpint_port (.*);
    gpint_board u_gpint_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
        .pin_in(pin_in));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] er = gpint_pkg::GPINT_RESP_OKAY);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input logic [1:0] er = gpint_pkg::GPINT_RESP_OKAY);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    // drive lands two cycles after the write is taken, so three edges is safe
    task automatic pins();
        repeat (3) @(posedge aclk);
        check(pin_out, exp_out & dir);
        check(pin_oe_n, ~dir);
    endtask

    task automatic settle(input logic [31:0] lvl);
        ext <= lvl;
        repeat (8) @(posedge aclk);
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(gpint_pkg::GPINT_OFF_DIR, 32'h0);
        wr(gpint_pkg::GPINT_OFF_CFG, 32'h0000_0101);
        wr(gpint_pkg::GPINT_OFF_CFG, 32'h0005_0001);
        wr(gpint_pkg::GPINT_OFF_CFG, 32'h0014_0100);
        dir = 32'h0000_0021;
        exp_out = 32'h0000_0001;
        pins();
        exp_out = 32'h0000_a5f0;
        wr(gpint_pkg::GPINT_OFF_OUT, exp_out);
        dir = 32'h0000_ffff;
        wr(gpint_pkg::GPINT_OFF_DIR, dir);
        rd(gpint_pkg::GPINT_OFF_DIR, dir);
        pins();
        wr(gpint_pkg::GPINT_OFF_PINWR, 32'h0002_0001);
        wr(gpint_pkg::GPINT_OFF_PINWR, 32'h0004_0000);
        wr(gpint_pkg::GPINT_OFF_PINWR, 32'h001f_0001);
        exp_out = (exp_out | 32'h8000_0004) & ~32'h10;
        pins();
        wr(gpint_pkg::GPINT_OFF_SET, 32'h8000_000f);
        exp_out = exp_out | 32'h8000_000f;
        pins();
        wr(gpint_pkg::GPINT_OFF_CLR, 32'h0000_00f3);
        exp_out = exp_out & ~32'h0000_00f3;
        pins();
        wr(gpint_pkg::GPINT_OFF_TGL, 32'h0000_ff00);
        exp_out = exp_out ^ 32'h0000_ff00;
        pins();
        rd(gpint_pkg::GPINT_OFF_OUT, exp_out);
        settle(32'h5a5a_3c3c);
        rd(gpint_pkg::GPINT_OFF_IN, (exp_out & dir) | (ext & ~dir));
        wr(gpint_pkg::GPINT_OFF_IN, 32'h0, ERR);
        rd(6'h38, 32'h0, ERR);
        ext <= 32'h0;
        wr(gpint_pkg::GPINT_OFF_TYPSEL, 32'h1);
        wr(gpint_pkg::GPINT_OFF_TYPE, 32'hffff_ffff);
        // pin 16 high, 17 rise, 18 low, 19 fall
        for (int k = 0; k < 4; k++) begin
            wr(gpint_pkg::GPINT_OFF_TYPSEL, 32'(k));
            wr(gpint_pkg::GPINT_OFF_TYPE, 32'h0001_0000 << k);
        end
        repeat (8) @(posedge aclk);
        wr(gpint_pkg::GPINT_OFF_STAT, 32'hffff_ffff);
        rd(gpint_pkg::GPINT_OFF_STAT, 32'h0004_0000);
        settle(32'h000f_0000);
        rd(gpint_pkg::GPINT_OFF_STAT, 32'h0007_0000);
        settle(32'h0007_0000);
        rd(gpint_pkg::GPINT_OFF_STAT, 32'h0009_0000);
        settle(32'h0004_0000);
        rd(gpint_pkg::GPINT_OFF_STAT, 32'h0001_0000);
        settle(32'h000e_0000);
        settle(32'h0006_0000);
        wr(gpint_pkg::GPINT_OFF_IENSET, 32'h0002_0020);
        repeat (4) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        wr(gpint_pkg::GPINT_OFF_STAT, 32'h0002_0000);
        repeat (4) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd(gpint_pkg::GPINT_OFF_STAT, 32'h0008_0000);
        wr(gpint_pkg::GPINT_OFF_IENCLR, 32'h0002_0000);
        rd(gpint_pkg::GPINT_OFF_IEN, 32'h0000_0020);
        settle(32'h000e_0000);
        settle(32'h0006_0000);
        check({31'h0, irq}, 32'h0);
        wr(gpint_pkg::GPINT_OFF_IENSET, 32'h0008_0000);
        repeat (4) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        rd(gpint_pkg::GPINT_OFF_STAT, 32'h0008_0000);
        repeat (4) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule
